// [rtl/aer_pkg.sv]
package aer_pkg;

  // Register offsets within the extended configuration space.
  localparam int unsigned AER_ADDR_W   = 12;
  localparam logic [11:0] AER_SEV_OFF  = 12'h10C;
  localparam logic [11:0] AER_CST_OFF  = 12'h110;
  localparam logic [11:0] AER_CMSK_OFF = 12'h114;
  localparam logic [11:0] AER_HDR_OFF0 = 12'h11C;
  localparam logic [11:0] AER_HDR_OFF1 = 12'h120;
  localparam logic [11:0] AER_HDR_OFF2 = 12'h124;
  localparam logic [11:0] AER_HDR_OFF3 = 12'h128;
  localparam logic [11:0] AER_IST_OFF  = 12'h180;
  localparam logic [11:0] AER_IMSK_OFF = 12'h184;

  // Implemented bits and reset values.
  localparam logic [31:0] AER_SEV_IMPL   = 32'h003F_F011;
  localparam logic [31:0] AER_SEV_RESET  = 32'h0006_2011;
  localparam logic [31:0] AER_CORR_IMPL  = 32'h0000_31C1;
  localparam logic [31:0] AER_CST_RESET  = 32'h0000_0000;
  localparam logic [31:0] AER_CMSK_RESET = 32'h0000_2000;
  localparam logic [31:0] AER_IRQ_IMPL   = 32'h0000_0007;
  localparam logic [31:0] AER_IST_RESET  = 32'h0000_0000;
  localparam logic [31:0] AER_IMSK_RESET = 32'h0000_0000;
  localparam logic [31:0] AER_HDR_RESET  = 32'h0000_0000;

  // Correctable status and mask field positions.
  localparam int unsigned AER_RX_ERR_BIT    = 0;
  localparam int unsigned AER_BAD_TLP_BIT   = 6;
  localparam int unsigned AER_BAD_DLLP_BIT  = 7;
  localparam int unsigned AER_REPLAY_RO_BIT = 8;
  localparam int unsigned AER_REPLAY_TO_BIT = 12;
  localparam int unsigned AER_ADV_NF_BIT    = 13;

  // Interrupt status field positions.
  localparam int unsigned AER_IRQ_COR_BIT   = 0;
  localparam int unsigned AER_IRQ_NF_BIT    = 1;
  localparam int unsigned AER_IRQ_FATAL_BIT = 2;

  // Number of header doublewords captured.
  localparam int unsigned AER_HDR_DWORDS = 4;

  // Kind of error message sent toward the root complex.
  typedef enum logic [1:0] {
    MSG_COR,
    MSG_NONFATAL,
    MSG_FATAL
  } aer_msg_kind_type;

endpackage : aer_pkg

// [rtl/aer_regs.sv]
// Chosen here: strobed register access.
`timescale 1ns/1ps
// Functional notes
// R1 - Severity bits 0, 4, 12..21 are read-write; one means fatal, zero non-fatal.
// R2 - Correctable status flags reset to zero, stick, clear by writing one.
// R3 - Receiver error sets correctable status bit 0.
// R4 - Bad received transaction packet sets correctable status bit 6.
// R5 - Bad received link layer packet sets correctable status bit 7.
// R6 - Replay counter rollover sets correctable status bit 8.
// R7 - Replay timer expiry sets correctable status bit 12.
// R8 - Advisory non-fatal error sets correctable status bit 13.
// R9 - Mask bit 0 stops logging and messages for receiver errors; resets zero.
// R10 - Mask bit 6 stops logging and messages for bad packets; resets zero.
// R11 - Mask bit 7 stops logging and messages for bad link packets; resets zero.
// R12 - Mask bit 8 stops logging and messages for replay rollover; resets zero.
// R13 - Mask bit 12 stops logging and messages for replay timeout; resets zero.
// R14 - Mask bit 13 stops logging and messages for advisory errors; resets one.
// R15 - Unmasked logged error captures four header doublewords, big-endian.
// R16 - Unmasked uncorrectable error sends fatal or non-fatal message per severity.
// R17 - Reserved bits read zero and ignore writes.
module aer_regs
  import aer_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic [AER_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]           regWrData,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic      [31:0]           regRdData,
  input  wire logic                  rxErrEvent,
  input  wire logic                  badTlpEvent,
  input  wire logic                  badDllpEvent,
  input  wire logic                  replayRollEvent,
  input  wire logic                  replayTimeoutEvent,
  input  wire logic                  advisoryNfEvent,
  input  wire logic [31:0]           uncorrEvent,
  input  wire logic [31:0]           uncorrMask,
  input  wire logic [127:0]          tlpHeader,
  output logic                       errMsgValid,
  output aer_msg_kind_type           errMsgKind,
  output logic                       irq
);

  // Whole state of the block in one record.
  typedef struct packed {
    logic [31:0]                          sev;
    logic [31:0]                          cst;
    logic [31:0]                          cmsk;
    logic [AER_HDR_DWORDS-1:0][31:0]      hdr;
    logic [31:0]                          ist;
    logic [31:0]                          imsk;
    logic [31:0]                          rdData;
    logic                                 msgValid;
    aer_msg_kind_type                     msgKind;
  } aer_state_type;

  aer_state_type st_q;
  aer_state_type st_d;

  logic [31:0] corrEv;
  logic [31:0] corrLog;
  logic [31:0] uncLog;
  logic [31:0] cstClr;
  logic [31:0] istClr;
  logic [31:0] irqEv;
  logic        corHit;
  logic        nfHit;
  logic        fatalHit;
  logic        wrSev;
  logic        wrCst;
  logic        wrCmsk;
  logic        wrIst;
  logic        wrImsk;

  // Sticky update: a new event wins over a write-one clear in the same cycle.
  function automatic logic [31:0] stickUpdate(
    input logic [31:0] old,
    input logic [31:0] setBits,
    input logic [31:0] clrBits,
    input logic [31:0] impl
  );
    stickUpdate = ((old & ~clrBits) | setBits) & impl;
  endfunction : stickUpdate

  // Picks header doubleword n; byte 4n lands in bits 31:24.
  // The header arrives in wire order with byte k at bits 8k+7:8k.
  function automatic logic [31:0] beDword(
    input logic [127:0] hdrIn,
    input int unsigned  n
  );
    logic [31:0] w;
    w = '0;
    for (int b = 0; b < 4; b++) begin
      w[31-8*b -: 8] = hdrIn[8*(4*n+b) +: 8];
    end
    beDword = w;
  endfunction : beDword

  // Write decode of the plain register port.
  assign wrSev  = regWrite && (regAddr == AER_SEV_OFF);
  assign wrCst  = regWrite && (regAddr == AER_CST_OFF);
  assign wrCmsk = regWrite && (regAddr == AER_CMSK_OFF);
  assign wrIst  = regWrite && (regAddr == AER_IST_OFF);
  assign wrImsk = regWrite && (regAddr == AER_IMSK_OFF);
  assign cstClr = wrCst ? regWrData : '0;
  assign istClr = wrIst ? regWrData : '0;

  // Gather the correctable events into their status positions.
  always_comb begin
    corrEv = '0;
    corrEv[AER_RX_ERR_BIT]    = rxErrEvent;          // [R3]
    corrEv[AER_BAD_TLP_BIT]   = badTlpEvent;         // [R4]
    corrEv[AER_BAD_DLLP_BIT]  = badDllpEvent;        // [R5]
    corrEv[AER_REPLAY_RO_BIT] = replayRollEvent;     // [R6]
    corrEv[AER_REPLAY_TO_BIT] = replayTimeoutEvent;  // [R7]
    corrEv[AER_ADV_NF_BIT]    = advisoryNfEvent;     // [R8]
  end

  // Masked events still set status but are neither logged nor reported.
  assign corrLog  = corrEv & ~st_q.cmsk & AER_CORR_IMPL; // [R9] [R10] [R11] [R12] [R13] [R14]
  assign uncLog   = uncorrEvent & ~uncorrMask & AER_SEV_IMPL;
  assign corHit   = |corrLog;
  assign fatalHit = |(uncLog & st_q.sev);                // [R16]
  assign nfHit    = |(uncLog & ~st_q.sev);               // [R16]

  // Interrupt events flag each kind of logged error seen this cycle.
  always_comb begin
    irqEv = '0;
    irqEv[AER_IRQ_COR_BIT]   = corHit;
    irqEv[AER_IRQ_NF_BIT]    = nfHit;
    irqEv[AER_IRQ_FATAL_BIT] = fatalHit;
  end

  // Next-state logic for the whole block.
  always_comb begin
    st_d = st_q;
    // Severity register keeps only implemented bits.
    if (wrSev) begin
      st_d.sev = regWrData & AER_SEV_IMPL;                 // [R1] [R17]
    end
    // Correctable status sets on every event, masked or not.
    st_d.cst = stickUpdate(st_q.cst, corrEv, cstClr, AER_CORR_IMPL); // [R2] [R17]
    if (wrCmsk) begin
      st_d.cmsk = regWrData & AER_CORR_IMPL;               // [R17]
    end
    // Any unmasked error at an implemented bit refreshes the header log.
    if (corHit || nfHit || fatalHit) begin
      for (int n = 0; n < AER_HDR_DWORDS; n++) begin
        st_d.hdr[n] = beDword(tlpHeader, n);               // [R15]
      end
    end
    // One message per cycle; fatal beats non-fatal beats correctable.
    st_d.msgValid = corHit || nfHit || fatalHit;
    if (fatalHit) begin
      st_d.msgKind = MSG_FATAL;                            // [R16]
    end else if (nfHit) begin
      st_d.msgKind = MSG_NONFATAL;                         // [R16]
    end else if (corHit) begin
      st_d.msgKind = MSG_COR;
    end
    // Interrupt status and mask.
    st_d.ist = stickUpdate(st_q.ist, irqEv, istClr, AER_IRQ_IMPL);
    if (wrImsk) begin
      st_d.imsk = regWrData & AER_IRQ_IMPL;
    end
    // Read data stands only in the cycle after the read strobe.
    st_d.rdData = '0;
    if (regRead) begin
      case (regAddr)
        AER_SEV_OFF:  st_d.rdData = st_q.sev;
        AER_CST_OFF:  st_d.rdData = st_q.cst;
        AER_CMSK_OFF: st_d.rdData = st_q.cmsk;
        AER_HDR_OFF0: st_d.rdData = st_q.hdr[0];
        AER_HDR_OFF1: st_d.rdData = st_q.hdr[1];
        AER_HDR_OFF2: st_d.rdData = st_q.hdr[2];
        AER_HDR_OFF3: st_d.rdData = st_q.hdr[3];
        AER_IST_OFF:  st_d.rdData = st_q.ist;
        AER_IMSK_OFF: st_d.rdData = st_q.imsk;
        default:      st_d.rdData = '0;
      endcase
    end
  end

  // State register with documented reset values.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q.sev      <= AER_SEV_RESET;                       // [R1]
      st_q.cst      <= AER_CST_RESET;                       // [R2]
      st_q.cmsk     <= AER_CMSK_RESET;                      // [R9] [R14]
      st_q.hdr      <= {AER_HDR_DWORDS{AER_HDR_RESET}};
      st_q.ist      <= AER_IST_RESET;
      st_q.imsk     <= AER_IMSK_RESET;
      st_q.rdData   <= '0;
      st_q.msgValid <= 1'b0;
      st_q.msgKind  <= MSG_COR;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state record.
  assign regRdData   = st_q.rdData;
  assign errMsgValid = st_q.msgValid;
  assign errMsgKind  = st_q.msgKind;
  assign irq         = |(st_q.ist & st_q.imsk);

  // A severity write shows up masked to implemented bits.
  a_sev_write: assert property ( // [R1]
    @(posedge clock) disable iff (!nrst)
    wrSev |=> (st_q.sev == ($past(regWrData) & AER_SEV_IMPL))
  ) else $error("Severity write not stored.");

  // A set status flag only falls when a one was written to it.
  a_cst_sticky: assert property ( // [R2]
    @(posedge clock) disable iff (!nrst)
    1'b1 |=> ((($past(st_q.cst) & ~$past(cstClr)) & ~st_q.cst) == '0)
  ) else $error("Correctable flag dropped without clear.");

  // Receiver error sets bit 0 even against a clear.
  a_rx_status: assert property ( // [R3]
    @(posedge clock) disable iff (!nrst)
    rxErrEvent |=> st_q.cst[AER_RX_ERR_BIT]
  ) else $error("Receiver error flag not set.");

  // Bad transaction packet sets bit 6.
  a_tlp_status: assert property ( // [R4]
    @(posedge clock) disable iff (!nrst)
    badTlpEvent |=> st_q.cst[AER_BAD_TLP_BIT]
  ) else $error("Bad packet flag not set.");

  // Bad link packet sets bit 7.
  a_dllp_status: assert property ( // [R5]
    @(posedge clock) disable iff (!nrst)
    badDllpEvent |=> st_q.cst[AER_BAD_DLLP_BIT]
  ) else $error("Bad link packet flag not set.");

  // Replay rollover sets bit 8.
  a_roll_status: assert property ( // [R6]
    @(posedge clock) disable iff (!nrst)
    replayRollEvent |=> st_q.cst[AER_REPLAY_RO_BIT]
  ) else $error("Replay rollover flag not set.");

  // Replay timeout sets bit 12.
  a_timeout_status: assert property ( // [R7]
    @(posedge clock) disable iff (!nrst)
    replayTimeoutEvent |=> st_q.cst[AER_REPLAY_TO_BIT]
  ) else $error("Replay timeout flag not set.");

  // Advisory error sets bit 13.
  a_advisory_status: assert property ( // [R8]
    @(posedge clock) disable iff (!nrst)
    advisoryNfEvent |=> st_q.cst[AER_ADV_NF_BIT]
  ) else $error("Advisory flag not set.");

  // Fully masked correctable events produce no message.
  a_mask_silence: assert property ( // [R9] [R10] [R11] [R12] [R13] [R14]
    @(posedge clock) disable iff (!nrst)
    ((|corrEv) && ((corrEv & ~st_q.cmsk) == '0) && (uncLog == '0)) |=> !errMsgValid
  ) else $error("Masked correctable event was reported.");

  // An unmasked correctable event produces a message next cycle.
  a_corr_report: assert property ( // [R9] [R14]
    @(posedge clock) disable iff (!nrst)
    (|(corrEv & ~st_q.cmsk)) |=> errMsgValid
  ) else $error("Unmasked correctable event not reported.");

  // A logged error captures the first header doubleword big-endian.
  a_hdr_capture: assert property ( // [R15]
    @(posedge clock) disable iff (!nrst)
    (corHit || nfHit || fatalHit) |=>
      (st_q.hdr[0] == {$past(tlpHeader[7:0]), $past(tlpHeader[15:8]),
                       $past(tlpHeader[23:16]), $past(tlpHeader[31:24])})
  ) else $error("Header log not captured.");

  // Uncorrectable errors set to fatal in the severity register are reported as fatal.
  a_sev_message: assert property ( // [R16]
    @(posedge clock) disable iff (!nrst)
    (|(uncorrEvent & ~uncorrMask & AER_SEV_IMPL & st_q.sev)) |=>
      (errMsgValid && (errMsgKind == MSG_FATAL))
  ) else $error("Fatal error not reported as fatal.");

  // Non-fatal uncorrectable errors with no fatal one beside them are reported as non-fatal.
  a_nf_message: assert property ( // [R16]
    @(posedge clock) disable iff (!nrst)
    (nfHit && !fatalHit) |=> (errMsgValid && (errMsgKind == MSG_NONFATAL))
  ) else $error("Non-fatal error misreported.");

  // Reserved bits of the three registers stay zero.
  a_reserved_zero: assert property ( // [R17]
    @(posedge clock) disable iff (!nrst)
    ((st_q.sev & ~AER_SEV_IMPL) == '0) &&
    ((st_q.cst & ~AER_CORR_IMPL) == '0) &&
    ((st_q.cmsk & ~AER_CORR_IMPL) == '0)
  ) else $error("Reserved bit became set.");

  // A fatal error with its interrupt mask bit set raises the interrupt next cycle.
  a_irq_level: assert property (
    @(posedge clock) disable iff (!nrst)
    (fatalHit && st_q.imsk[AER_IRQ_FATAL_BIT]) |=> irq
  ) else $error("Interrupt missing after fatal error.");

  // Right after reset release the severity, status and mask registers still show their reset values.
  a_reset_values: assert property ( // [R1] [R2] [R14]
    @(posedge clock)
    $rose(nrst) |-> ((st_q.sev == AER_SEV_RESET) && (st_q.cst == AER_CST_RESET) &&
                     (st_q.cmsk == AER_CMSK_RESET))
  ) else $error("Register left reset with a wrong value.");

  // A mask write shows up limited to implemented bits.
  a_cmsk_write: assert property ( // [R9] [R14] [R17]
    @(posedge clock) disable iff (!nrst)
    wrCmsk |=> (st_q.cmsk == ($past(regWrData) & AER_CORR_IMPL))
  ) else $error("Correctable mask write not stored.");

  // Writing ones clears those flags when no event arrives at the same time.
  a_cst_clear: assert property ( // [R2]
    @(posedge clock) disable iff (!nrst)
    (wrCst && !(|corrEv)) |=> ((st_q.cst & $past(regWrData)) == '0)
  ) else $error("Correctable flag not cleared by a one.");

  // Read data returns to zero when no read was asked for.
  a_rd_idle: assert property (
    @(posedge clock) disable iff (!nrst)
    !regRead |=> (regRdData == '0)
  ) else $error("Read data stood without a read.");

  // No logged error means no message in the next cycle.
  a_msg_pulse: assert property ( // [R9] [R16]
    @(posedge clock) disable iff (!nrst)
    !(corHit || nfHit || fatalHit) |=> !errMsgValid
  ) else $error("Message sent without a logged error.");

  // The header log keeps its contents while nothing is logged.
  a_hdr_hold: assert property ( // [R15]
    @(posedge clock) disable iff (!nrst)
    !(corHit || nfHit || fatalHit) |=> $stable(st_q.hdr)
  ) else $error("Header log changed without a logged error.");

  // A logged error captures the last header doubleword big-endian.
  a_hdr_last: assert property ( // [R15]
    @(posedge clock) disable iff (!nrst)
    (corHit || nfHit || fatalHit) |=>
      (st_q.hdr[3] == {$past(tlpHeader[103:96]), $past(tlpHeader[111:104]),
                       $past(tlpHeader[119:112]), $past(tlpHeader[127:120])})
  ) else $error("Last header doubleword not captured.");

endmodule : aer_regs

// [verif/aer_link_model.sv]
`timescale 1ns/1ps
// Link-side stand-in that forwards requested error pulses and the offending header.
module aer_link_model
  import aer_pkg::*;
(
  input  wire logic [5:0]   corrReq,
  input  wire logic [31:0]  uncReq,
  input  wire logic [127:0] hdrReq,
  output logic      [5:0]   corrEvent,
  output logic      [31:0]  uncEvent,
  output logic      [127:0] hdrBus
);
  // The header lines hold fresh data only beside an event; otherwise the inverse stands.
  always_comb begin
    corrEvent = corrReq;
    uncEvent  = uncReq;
    hdrBus    = (|corrReq || |uncReq) ? hdrReq : ~hdrReq;
  end
endmodule : aer_link_model

// [verif/aer_regs_tb.sv]
`timescale 1ns/1ps
// Self-checking bench for the error reporting register bank.
module aer_regs_tb
  import aer_pkg::*;
;
  logic             clock, nrst, regWrite, regRead, rdSeen, irq, errMsgValid;
  logic [11:0]      regAddr;
  logic [31:0]      regWrData, regRdData, uncorrMask, uncReq, uncEvent;
  logic [31:0]      sevE, cstE, cmskE, istE, imskE, uMaskE;
  logic [31:0]      hdrE [4];
  logic [5:0]       corrReq, corrEvent;
  logic [127:0]     hdrReq, hdrBus;
  aer_msg_kind_type errMsgKind;
  aer_msg_kind_type expMsg [$];
  logic [31:0]      expRd [$];
  integer           seed;
  int               miscompares, samplesChecked;

  // The clock toggles every 50 ns, a period of 100 ns.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  aer_link_model LINK (.corrReq(corrReq), .uncReq(uncReq), .hdrReq(hdrReq),
    .corrEvent(corrEvent), .uncEvent(uncEvent), .hdrBus(hdrBus));
  aer_regs DUT (.clock(clock), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .rxErrEvent(corrEvent[0]), .badTlpEvent(corrEvent[1]), .badDllpEvent(corrEvent[2]),
    .replayRollEvent(corrEvent[3]), .replayTimeoutEvent(corrEvent[4]),
    .advisoryNfEvent(corrEvent[5]), .uncorrEvent(uncEvent), .uncorrMask(uncorrMask),
    .tlpHeader(hdrBus), .errMsgValid(errMsgValid), .errMsgKind(errMsgKind), .irq(irq));

  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpWord

  task automatic cmpKind(input aer_msg_kind_type got, input aer_msg_kind_type exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpKind

  task automatic report_and_stop;
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // Expected register contents as software should see them.
  function automatic logic [31:0] rdVal(input logic [11:0] a);
    if (a >= AER_HDR_OFF0 && a <= AER_HDR_OFF3 && a[1:0] == 2'h0) begin
      return hdrE[2'((a - AER_HDR_OFF0) >> 2)];
    end
    case (a)
      AER_SEV_OFF:  return sevE;
      AER_CST_OFF:  return cstE;
      AER_CMSK_OFF: return cmskE;
      AER_IST_OFF:  return istE;
      AER_IMSK_OFF: return imskE;
      default:      return 32'h0000_0000;
    endcase
  endfunction : rdVal

  // Resets the design and the expected state together.
  task automatic doReset;
    nrst <= 1'b0;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    corrReq <= 6'h00;
    uncReq <= 32'h0000_0000;
    sevE = 32'h0006_2011;
    cstE = 32'h0000_0000;
    cmskE = 32'h0000_2000;
    istE = 32'h0000_0000;
    imskE = 32'h0000_0000;
    hdrE = '{default: 32'h0000_0000};
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
  endtask : doReset

  // One bus cycle with optional events; the expected state moves at the same edge.
  task automatic cyc(input logic w, input logic r, input logic [11:0] a,
                     input logic [31:0] d, input logic [5:0] ce, input logic [31:0] ue);
    logic [127:0] h;
    logic [31:0]  cs, cu, un, uf, nf;
    h = {$random(seed), $random(seed), $random(seed), $random(seed)};
    regWrite   <= w;
    regRead    <= r;
    regAddr    <= a;
    regWrData  <= d;
    corrReq    <= ce;
    uncReq     <= ue;
    hdrReq     <= h;
    uncorrMask <= uMaskE;
    @(posedge clock);
    if (r) expRd.push_back(rdVal(a));
    cs = {18'h0, ce[5:4], 3'h0, ce[3:1], 5'h0, ce[0]};
    cu = cs & ~cmskE;
    un = ue & ~uMaskE & 32'h003F_F011;
    uf = un & sevE;
    nf = un & ~sevE;
    if (w && a == AER_SEV_OFF) sevE = d & 32'h003F_F011;
    if (w && a == AER_CST_OFF) cstE = cstE & ~d;
    if (w && a == AER_CMSK_OFF) cmskE = d & 32'h0000_31C1;
    if (w && a == AER_IST_OFF) istE = istE & ~d;
    if (w && a == AER_IMSK_OFF) imskE = d & 32'h0000_0007;
    cstE = cstE | cs;
    if (|un || |cu) begin
      expMsg.push_back(|uf ? MSG_FATAL : (|un ? MSG_NONFATAL : MSG_COR));
      if (|cu) istE[AER_IRQ_COR_BIT] = 1'b1;
      if (|nf) istE[AER_IRQ_NF_BIT] = 1'b1;
      if (|uf) istE[AER_IRQ_FATAL_BIT] = 1'b1;
      for (int n = 0; n < 4; n++) begin
        hdrE[n] = {h[32*n+:8], h[32*n+8+:8], h[32*n+16+:8], h[32*n+24+:8]};
      end
    end
  endtask : cyc

  // Reads every mapped register and the unmapped holes between them.
  task automatic readAll;
    for (logic [11:0] a = 12'h10C; a <= 12'h188; a += 12'h004) begin
      cyc(1'b0, 1'b1, a, 32'h0, 6'h0, 32'h0);
    end
    cyc(1'b0, 1'b1, 12'h000, 32'h0, 6'h0, 32'h0);
  endtask : readAll

  // Read data, messages and the interrupt level are compared once settled.
  always @(posedge clock) rdSeen <= regRead;
  always @(negedge clock) begin
    if (rdSeen === 1'b1) cmpWord(regRdData, expRd.pop_front());
    else cmpWord(regRdData, 32'h0000_0000);
    if (errMsgValid !== 1'b0 && expMsg.size() == 0) cmpWord(32'h1, 32'h0);
    else if (errMsgValid !== 1'b0) cmpKind(errMsgKind, expMsg.pop_front());
    cmpWord({31'h0, irq}, {31'h0, |(istE & imskE)});
  end

  // A hung run is cut short after a fixed number of cycles.
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end

  // Main sequence of scenarios.
  initial begin
    seed = 32'hE1E8;
    miscompares = 0;
    samplesChecked = 0;
    uMaskE = 32'h0;
    {regAddr, regWrData, hdrReq, uncorrMask} = '0;
    doReset();
    readAll();
    cyc(1'b1, 1'b0, AER_SEV_OFF, 32'hFFFF_FFFF, 6'h0, 32'h0);
    cyc(1'b1, 1'b0, AER_CMSK_OFF, 32'hFFFF_FFFF, 6'h0, 32'h0);
    cyc(1'b1, 1'b0, 12'h118, 32'hFFFF_FFFF, 6'h0, 32'h0);
    cyc(1'b0, 1'b0, 12'h0, 32'h0, 6'h3F, 32'h0);
    readAll();
    cyc(1'b1, 1'b0, AER_CMSK_OFF, 32'h0, 6'h0, 32'h0);
    cyc(1'b1, 1'b0, AER_IMSK_OFF, 32'h1, 6'h0, 32'h0);
    for (int i = 0; i < 6; i++) begin
      cyc(1'b1, 1'b0, AER_IST_OFF, 32'h1, 6'h0, 32'h0);
      cyc(1'b1, 1'b0, AER_CST_OFF, 32'hFFFF_FFFF, 6'h0, 32'h0);
      cyc(1'b0, 1'b0, 12'h0, 32'h0, 6'(1 << i), 32'h0);
      cyc(1'b1, 1'b0, AER_CST_OFF, 32'h0, 6'h0, 32'h0);
      readAll();
    end
    cyc(1'b1, 1'b0, AER_IMSK_OFF, 32'h6, 6'h0, 32'h0);
    for (int i = 0; i < 24; i++) begin
      cyc(1'b1, 1'b0, AER_SEV_OFF, $random(seed), 6'h0, 32'h0);
      cyc(1'b0, 1'b0, 12'h0, 32'h0, 6'h0, 32'h1 << i);
      cyc(1'b0, 1'b1, AER_IST_OFF, 32'h0, 6'h0, 32'h0);
      cyc(1'b1, 1'b0, AER_IST_OFF, 32'h7, 6'h0, 32'h0);
    end
    cyc(1'b1, 1'b0, AER_CMSK_OFF, $random(seed), 6'h0, 32'h0);
    for (int i = 0; i < 40; i++) begin
      uMaskE = $random(seed);
      cyc(1'b1, 1'b0, AER_CST_OFF, $random(seed), 6'($random(seed)), $random(seed));
    end
    readAll();
    doReset();
    readAll();
    cyc(1'b0, 1'b0, 12'h0, 32'h0, 6'h0, 32'h0);
    cmpWord(32'(expMsg.size()), 32'h0);
    report_and_stop();
  end
endmodule : aer_regs_tb
